// ===== verilog/leb_pkg.sv
// Package of constants for the leading-edge blanking control block
package leb_pkg;
   // Register byte offsets
   localparam logic [11:0] LEB_CTRL_OFF = 12'h000;
   localparam logic [11:0] LEB_PERIOD_OFF = 12'h004;
   localparam logic [11:0] LEB_AUX_OFF = 12'h008;
   localparam logic [11:0] LEB_STAT_OFF = 12'h00c;
   // Field positions in the control register
   localparam int LEB_HI_RISE_POS = 15;
   localparam int LEB_HI_FALL_POS = 14;
   localparam int LEB_LO_RISE_POS = 13;
   localparam int LEB_LO_FALL_POS = 12;
   localparam int LEB_FAULT_EN_POS = 11;
   localparam int LEB_CURLIM_EN_POS = 10;
   localparam int LEB_SEL_HIGH_POS = 5;
   localparam int LEB_SEL_LOW_POS = 4;
   localparam int LEB_HI_HIGH_POS = 3;
   localparam int LEB_HI_LOW_POS = 2;
   localparam int LEB_LO_HIGH_POS = 1;
   localparam int LEB_LO_LOW_POS = 0;
   // Implemented bits of the control register
   localparam logic [15:0] LEB_CTRL_MASK = 16'hfc3f;
   // Reset values, then the source select width and source count
   localparam logic [15:0] LEB_CTRL_RST = 16'h0000;
   localparam logic [15:0] LEB_PERIOD_RST = 16'h0000;
   localparam logic [1:0] LEB_AUX_RST = 2'h0;
   localparam logic [15:0] LEB_CNT_RST = 16'h0000;
   localparam int LEB_SRC_W = 2;
   localparam int LEB_SRC_N = 4;
endpackage

// ===== verilog/leb_sync_if.sv
// Interface carrying raw and synchronised channel pins
`timescale 1ns/10ps
interface leb_sync_if;
   logic [3:0] raw;
   logic [3:0] synced;
   modport src(output raw, input synced);
   modport snk(input raw, output synced);
endinterface

// ===== verilog/leb_sync.sv
// Two-stage synchroniser for the channel input pins
`timescale 1ns/10ps
module leb_sync (
   input wire logic sys_clk, // Clock
   input wire logic reset, // Sync reset
   input wire logic clk_en, // Clock enable
   leb_sync_if.snk sp // Pin group
);
   import leb_pkg::*;
   typedef struct packed {
      logic [3:0] s1;
      logic [3:0] s2;
   } leb_sync_st_t;
   leb_sync_st_t st_reg;
   leb_sync_st_t st_next;
   always_comb begin
      st_next = st_reg;
      st_next.s1 = sp.raw;
      st_next.s2 = st_reg.s1;
   end
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         st_reg <= '0;
      end else if (clk_en) begin
         st_reg <= st_next;
      end
   end
   assign sp.synced = st_reg.s2;
endmodule

// ===== verilog/leb_ctrl.sv
// Leading-edge blanking control for one PWM channel, APB slave
// Functional notes
// - High-side rising edge starts blanking counter when its trigger bit set.
// - High-side falling edge starts blanking counter when its trigger bit set.
// - Low-side rising edge starts blanking counter when its trigger bit set.
// - Low-side falling edge starts blanking counter when its trigger bit set.
// - Fault blank enable masks the fault input during blanking.
// - Current-limit blank enable masks the current-limit input during blanking.
// - Blank inputs while selected blanking signal is high.
// - Blank inputs while selected blanking signal is low.
// - Blank inputs while high-side output is high.
// - Blank inputs while low-side output is low.
// - Unused control bits ignore writes and read zero.
// - Implemented control bits are read/write and reset to zero.
// - Blanking signal source picked by a select field in an auxiliary register.
//
// Added by the designer: the APB interface to the registers and the register offsets.
`timescale 1ns/10ps
module leb_ctrl (
   input wire logic sys_clk, // 100 MHz clock
   input wire logic reset, // Sync reset, active high
   input wire logic clk_en, // Freezes all state when low
   input wire logic psel, // APB select
   input wire logic penable, // APB enable
   input wire logic pwrite, // APB direction
   input wire logic [11:0] paddr, // APB byte address
   input wire logic [31:0] pwdata, // APB write data
   output logic [31:0] prdata, // APB read data
   output logic pready, // APB ready
   output logic pslverr, // APB error
   input wire logic high_side_output, // High-side PWM pin
   input wire logic low_side_output, // Low-side PWM pin
   input wire logic fault_in, // Selected fault input
   input wire logic curlim_in, // Selected current-limit input
   input wire logic [3:0] blank_src_in, // Candidate blanking signals
   output logic fault_out, // Fault after blanking
   output logic curlim_out, // Current limit after blanking
   output logic blank_active // Blanking in force
);
   import leb_pkg::*;

   typedef struct packed {
      logic [15:0] ctrl;
      logic [15:0] period;
      logic [LEB_SRC_W-1:0] blank_source_select;
      logic [15:0] cnt;
      logic hi_d;
      logic lo_d;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic fault_out;
      logic curlim_out;
      logic blank_active;
   } leb_st_t;

   leb_st_t st_reg;
   leb_st_t st_next;
   leb_sync_if sif();

   // Bit order: fault, current limit, high side, low side
   assign sif.raw = {fault_in, curlim_in, high_side_output, low_side_output};

   leb_sync u_sync (
      .sys_clk(sys_clk),
      .reset(reset),
      .clk_en(clk_en),
      .sp(sif.snk)
   );

   // Blanking sources also come from pins, so they get their own stages
   logic [3:0] src_s1_reg;
   logic [3:0] src_s2_reg;
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         src_s1_reg <= 4'h0;
         src_s2_reg <= 4'h0;
      end else if (clk_en) begin
         src_s1_reg <= blank_src_in;
         src_s2_reg <= src_s1_reg;
      end
   end

   function automatic logic rd_hit(input logic [11:0] a, input logic [11:0] off);
      rd_hit = (a == off);
   endfunction

   logic hi_s;
   logic lo_s;
   logic flt_s;
   logic cl_s;
   logic edge_trig;
   logic sel_sig;
   logic state_blank;
   logic cnt_blank;
   logic blank_any;
   logic acc;
   logic mapped;

   always_comb begin
      hi_s = sif.synced[1];
      lo_s = sif.synced[0];
      flt_s = sif.synced[3];
      cl_s = sif.synced[2];
      edge_trig = (st_reg.ctrl[LEB_HI_RISE_POS] && hi_s && !st_reg.hi_d) ||
         (st_reg.ctrl[LEB_HI_FALL_POS] && !hi_s && st_reg.hi_d) ||
         (st_reg.ctrl[LEB_LO_RISE_POS] && lo_s && !st_reg.lo_d) ||
         (st_reg.ctrl[LEB_LO_FALL_POS] && !lo_s && st_reg.lo_d);
      sel_sig = src_s2_reg[st_reg.blank_source_select];
      state_blank = (st_reg.ctrl[LEB_SEL_HIGH_POS] && sel_sig) ||
         (st_reg.ctrl[LEB_SEL_LOW_POS] && !sel_sig) ||
         (st_reg.ctrl[LEB_HI_HIGH_POS] && hi_s) ||
         (st_reg.ctrl[LEB_HI_LOW_POS] && !hi_s) ||
         (st_reg.ctrl[LEB_LO_HIGH_POS] && lo_s) ||
         (st_reg.ctrl[LEB_LO_LOW_POS] && !lo_s);
      cnt_blank = (st_reg.cnt != LEB_CNT_RST) || (edge_trig && st_reg.period != LEB_PERIOD_RST);
      blank_any = cnt_blank || state_blank;
      acc = psel && penable;
      mapped = rd_hit(paddr, LEB_CTRL_OFF) || rd_hit(paddr, LEB_PERIOD_OFF) ||
         rd_hit(paddr, LEB_AUX_OFF) || rd_hit(paddr, LEB_STAT_OFF);

      st_next = st_reg;
      st_next.hi_d = hi_s;
      st_next.lo_d = lo_s;
      // A new edge restarts the count, so overlapping edges stretch the window
      if (edge_trig) begin
         st_next.cnt = st_reg.period;
      end else if (st_reg.cnt != LEB_CNT_RST) begin
         st_next.cnt = st_reg.cnt - 16'h0001;
      end
      st_next.fault_out = flt_s && !(blank_any && st_reg.ctrl[LEB_FAULT_EN_POS]);
      st_next.curlim_out = cl_s && !(blank_any && st_reg.ctrl[LEB_CURLIM_EN_POS]);
      st_next.blank_active = blank_any;

      st_next.pready = 1'b0;
      st_next.pslverr = 1'b0;
      // Answer takes one wait state; pready drops after each access
      if (psel && !penable) begin
         st_next.pready = 1'b0;
      end else if (acc && !st_reg.pready) begin
         st_next.pready = 1'b1;
         st_next.pslverr = !mapped;
         st_next.prdata = 32'h0000_0000;
         if (pwrite) begin
            if (rd_hit(paddr, LEB_CTRL_OFF)) begin
               st_next.ctrl = pwdata[15:0] & LEB_CTRL_MASK;
            end
            if (rd_hit(paddr, LEB_PERIOD_OFF)) begin
               st_next.period = pwdata[15:0];
            end
            if (rd_hit(paddr, LEB_AUX_OFF)) begin
               st_next.blank_source_select = pwdata[LEB_SRC_W-1:0];
            end
         end else begin
            case (1'b1)
               rd_hit(paddr, LEB_CTRL_OFF): st_next.prdata = {16'h0000, st_reg.ctrl & LEB_CTRL_MASK};
               rd_hit(paddr, LEB_PERIOD_OFF): st_next.prdata = {16'h0000, st_reg.period};
               rd_hit(paddr, LEB_AUX_OFF): st_next.prdata = {30'h0000_0000, st_reg.blank_source_select};
               rd_hit(paddr, LEB_STAT_OFF): st_next.prdata = {st_reg.cnt, 13'h0000, st_reg.blank_active,
                  st_reg.curlim_out, st_reg.fault_out};
               default: st_next.prdata = 32'h0000_0000;
            endcase
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         st_reg <= '0;
         st_reg.ctrl <= LEB_CTRL_RST;
         st_reg.period <= LEB_PERIOD_RST;
         st_reg.blank_source_select <= LEB_AUX_RST;
         st_reg.cnt <= LEB_CNT_RST;
      end else if (clk_en) begin
         st_reg <= st_next;
      end
   end

   assign prdata = st_reg.prdata;
   assign pready = st_reg.pready;
   assign pslverr = st_reg.pslverr;
   assign fault_out = st_reg.fault_out;
   assign curlim_out = st_reg.curlim_out;
   assign blank_active = st_reg.blank_active;
endmodule

// ===== dv/leb_ctrl_assertions.sv
// Checker for the blanking control block ports
`timescale 1ns/10ps
module leb_ctrl_assertions
   import leb_pkg::*;
(
   input wire logic sys_clk, // Clock
   input wire logic reset, // Reset
   input wire logic clk_en, // Run
   input wire logic psel, // Select
   input wire logic penable, // Enable
   input wire logic pwrite, // Direction
   input wire logic [11:0] paddr, // Address
   input wire logic [31:0] pwdata, // Write data
   input wire logic [31:0] prdata, // Read data
   input wire logic pready, // Ready
   input wire logic pslverr, // Error
   input wire logic high_side_output, // High pin
   input wire logic low_side_output, // Low pin
   input wire logic fault_in, // Fault in
   input wire logic curlim_in, // Limit in
   input wire logic [3:0] blank_src_in, // Sources
   input wire logic fault_out, // Fault out
   input wire logic curlim_out, // Limit out
   input wire logic blank_active // Blanking
);
   logic [15:0] cfg_reg;
   // Shadow of the control word, taken at the completing edge
   always_ff @(posedge sys_clk) begin
      if (reset) cfg_reg <= 16'h0000;
      else if (psel && penable && pready && pwrite && !pslverr && paddr == LEB_CTRL_OFF)
         cfg_reg <= pwdata[15:0] & LEB_CTRL_MASK;
   end
   default clocking @(posedge sys_clk); endclocking
   default disable iff (reset);
   chk_ready_pulse: assert property (pready |=> !pready) else $error("ready longer than one cycle");
   chk_err_with_ready: assert property (pslverr |-> pready) else $error("error without ready");
   chk_reset_quiet: assert property (disable iff (1'b0) reset |=> !fault_out && !curlim_out && !blank_active)
      else $error("outputs active after reset");
   chk_unused_zero: assert property (pready && !pwrite && !pslverr && paddr == LEB_CTRL_OFF |->
      (prdata & ~{16'h0000, LEB_CTRL_MASK}) == 32'h0) else $error("unused control bits read nonzero");
   chk_hi_high_blank: assert property ((cfg_reg[3] && high_side_output) [*6] |-> blank_active)
      else $error("no blanking while high pin high");
   chk_lo_low_blank: assert property ((cfg_reg[0] && !low_side_output) [*6] |-> blank_active)
      else $error("no blanking while low pin low");
   chk_fault_passes: assert property ((!cfg_reg[11] && fault_in) [*6] |-> fault_out)
      else $error("fault masked without enable");
   chk_limit_passes: assert property ((!cfg_reg[10] && curlim_in) [*6] |-> curlim_out)
      else $error("limit masked without enable");
   chk_fault_masked: assert property ((cfg_reg[11] && cfg_reg[3] && high_side_output) [*6] |-> !fault_out)
      else $error("fault passed while blanked");
endmodule
bind leb_ctrl leb_ctrl_assertions i_leb_ctrl_assertions (.*);

// ===== dv/leb_ctrl_tb.sv
// Self-checking bench for the blanking control block
`timescale 1ns/10ps
module leb_ctrl_tb;
   import leb_pkg::*;
   logic sys_clk = 1'b0, reset = 1'b1, clk_en = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic high_side_output = 1'b0, low_side_output = 1'b0, fault_in = 1'b0, curlim_in = 1'b0;
   logic [3:0] blank_src_in = 4'h0;
   logic pready, pslverr, fault_out, curlim_out, blank_active, er, bl, r;
   logic [15:0] c;
   logic [1:0] a;
   int fails = 0, check_count = 0, cycles = 0;
   integer seed = 32'he17b;
   leb_ctrl i_leb_ctrl (.*);
   always #5 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 20000) begin
         fails++;
         stop_test();
      end
   end
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         fails++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task stop_test;
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // Entered just after a rising edge; leaves one idle edge so psel is never set twice
   task apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
      psel <= 1'b1; pwrite <= w; paddr <= ad; pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      do @(posedge sys_clk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0; penable <= 1'b0;
      @(posedge sys_clk);
   endtask
   function automatic logic sblank(input logic [15:0] k, input logic h, l, s);
      return (k[5] & s) | (k[4] & ~s) | (k[3] & h) | (k[2] & ~h) | (k[1] & l) | (k[0] & ~l);
   endfunction
   task settle(input int n, input logic eb, input logic chkb);
      repeat (n) @(posedge sys_clk);
      chk({31'h0, fault_out}, {31'h0, ~(c[11] & eb)});
      chk({31'h0, curlim_out}, {31'h0, ~(c[10] & eb)});
      if (chkb) chk({31'h0, blank_active}, {31'h0, eb});
   endtask
   initial begin
      repeat (4) @(posedge sys_clk);
      reset <= 1'b0;
      @(posedge sys_clk);
      apb(1'b0, LEB_CTRL_OFF, 32'h0);
      chk(rd, 32'h0);
      for (int i = 0; i < 6; i++) begin
         apb(1'b1, LEB_CTRL_OFF, $random(seed));
         c = pwdata[15:0];
         apb(1'b0, LEB_CTRL_OFF, 32'h0);
         chk(rd, {16'h0, c & LEB_CTRL_MASK});
      end
      apb(1'b0, 12'h010, 32'h0);
      chk({31'h0, er}, 32'h1);
      chk(rd, 32'h0);
      apb(1'b1, 12'h010, 32'h1);
      chk({31'h0, er}, 32'h1);
      apb(1'b1, LEB_PERIOD_OFF, 32'hffff_abcd);
      apb(1'b0, LEB_PERIOD_OFF, 32'h0);
      chk(rd, 32'h0000_abcd);
      apb(1'b1, LEB_PERIOD_OFF, 32'h0);
      apb(1'b1, LEB_AUX_OFF, 32'hffff_ffff);
      apb(1'b0, LEB_AUX_OFF, 32'h0);
      chk(rd, 32'h0000_0003);
      fault_in <= 1'b1; curlim_in <= 1'b1;
      for (int e = 0; e < 3; e++) for (int b = 0; b < 6; b++) begin
         a = $random(seed);
         apb(1'b1, LEB_AUX_OFF, {30'h0, a});
         c = (e == 0 ? 16'h0c00 : (e == 1 ? 16'h0800 : 16'h0400)) | (16'h1 << b);
         apb(1'b1, LEB_CTRL_OFF, {16'h0, c});
         for (int k = 0; k < 4; k++) begin
            high_side_output <= k[0]; low_side_output <= k[1]; blank_src_in <= $random(seed);
            @(posedge sys_clk);
            bl = sblank(c, k[0], k[1], blank_src_in[a]);
            settle(8, bl, e == 0);
         end
      end
      apb(1'b1, LEB_PERIOD_OFF, 32'd20);
      for (int t = 0; t < 4; t++) begin
         // Bit 12+t; odd t is a rising trigger, t above 1 is the high pin
         c = 16'h0c00 | (16'h1 << (12 + t));
         r = t[0];
         apb(1'b1, LEB_CTRL_OFF, {16'h0, c});
         high_side_output <= (t > 1) ? r : 1'b0; low_side_output <= (t > 1) ? 1'b0 : r;
         settle(30, 1'b0, 1'b1);
         if (t > 1) high_side_output <= ~r; else low_side_output <= ~r;
         settle(6, 1'b0, 1'b1);
         if (t > 1) high_side_output <= r; else low_side_output <= r;
         settle(6, 1'b1, 1'b1);
         apb(1'b0, LEB_STAT_OFF, 32'h0);
         chk({29'h0, rd[2:0]}, 32'h4);
         settle(30, 1'b0, 1'b1);
      end
      // Frozen state must hold the fault output through a pin change
      clk_en <= 1'b0;
      fault_in <= 1'b0;
      repeat (10) @(posedge sys_clk);
      chk({31'h0, fault_out}, 32'h1);
      clk_en <= 1'b1;
      repeat (6) @(posedge sys_clk);
      chk({31'h0, fault_out}, 32'h0);
      stop_test();
   end
endmodule
